// ===== verilog/hps_top.sv
// Purpose: Hot-plug slot status register bank of one switch port
// Assumes: Avalon-MM slave, word addressed, one wait state per access; a control write also waits while a command is busy or done is high
// Notes: Rules carried by this bank follow
//
// Implementation choice: the Avalon-MM slave port.
`timescale 1ns/10ps
`default_nettype none

module hps_top
(
    input wire logic SYS_CLK,
    input wire logic RESET,
    input wire logic [7:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    input wire logic ATTN_BUTTON,
    input wire logic POWER_FAULT,
    input wire logic LATCH_OPEN,
    input wire logic CARD_PRESENT,
    input wire logic INTERLOCK_ENGAGED,
    input wire logic LINK_ACTIVE,
    input wire logic EXP_DONE,
    output logic EXP_REQ,
    output logic [15:0] SLOT_CTRL,
    output logic HP_IRQ
);

    ////////////////////////////////////////////////////////////////////////
    // Functions

    // Byte enables widened to a bit mask
    function automatic logic [31:0] f_be_mask(input logic [3:0] be);
        logic [31:0] m;
        m = 32'h0;
        for (int i = 0; i < 4; i++)
        begin
            m[i*8 +: 8] = {8{be[i]}};
        end
        return m;
    endfunction

    // Slot status word as software reads it
    function automatic logic [15:0] f_status(input logic [8:0] flags, input logic [5:0] pins);
        logic [15:0] s;
        s = 16'h0;
        s[hps_pkg::BIT_BUTTON] = flags[hps_pkg::BIT_BUTTON];
        s[hps_pkg::BIT_PFAULT] = flags[hps_pkg::BIT_PFAULT];
        s[hps_pkg::BIT_LATCH_CHG] = flags[hps_pkg::BIT_LATCH_CHG];
        s[hps_pkg::BIT_PRES_CHG] = flags[hps_pkg::BIT_PRES_CHG];
        s[hps_pkg::BIT_CMD_DONE] = flags[hps_pkg::BIT_CMD_DONE];
        s[hps_pkg::BIT_LATCH_ST] = pins[hps_pkg::PIN_LATCH];
        s[hps_pkg::BIT_PRES_ST] = pins[hps_pkg::PIN_PRES];
        s[hps_pkg::BIT_LOCK_ST] = pins[hps_pkg::PIN_LOCK];
        s[hps_pkg::BIT_LINK_CHG] = flags[hps_pkg::BIT_LINK_CHG];
        return s;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    logic [5:0] pin_in;
    logic [5:0] meta_q;
    logic [5:0] meta_d;
    logic [5:0] sync_q;
    logic [5:0] sync_d;
    logic [5:0] prev_q;
    logic [5:0] prev_d;
    logic link_prev_q;
    logic link_prev_d;
    logic [8:0] evt_set;
    logic [8:0] evt_clr;
    logic [8:0] flags_q;
    logic [8:0] flags_d;
    logic [8:0] mask_q;
    logic [8:0] mask_d;
    logic [12:0] ctl_q;
    logic [12:0] ctl_d;
    logic busy_q;
    logic busy_d;
    logic req_q;
    logic req_d;
    logic cmd_done;
    logic cmd_blocked;
    logic waitreq_q;
    logic waitreq_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic [31:0] rd_word;
    logic [31:0] wr_mask;
    logic accept;
    logic wr_go;
    logic irq_q;
    logic irq_d;
    logic [8:0] irq_gate;

    assign pin_in = {EXP_DONE, INTERLOCK_ENGAGED, CARD_PRESENT, LATCH_OPEN, POWER_FAULT, ATTN_BUTTON};

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and edge memory

    always_comb
    begin
        meta_d = pin_in;
        sync_d = meta_q;
        prev_d = sync_q;
        link_prev_d = LINK_ACTIVE;
    end

    always_ff @(posedge SYS_CLK or posedge RESET)
    begin
        if (RESET)
        begin
            meta_q <= hps_pkg::PIN_RST;
            sync_q <= hps_pkg::PIN_RST;
            prev_q <= hps_pkg::PIN_RST;
            link_prev_q <= 1'b0;
        end
        else
        begin
            meta_q <= meta_d;
            sync_q <= sync_d;
            prev_q <= prev_d;
            link_prev_q <= link_prev_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus acceptance

    always_comb
    begin
        wr_mask = f_be_mask(AVS_BYTEENABLE);
        cmd_blocked = busy_q || sync_q[hps_pkg::PIN_DONE];
        // A control write waits while a command is busy or the synchronised done is high
        accept = (AVS_READ || AVS_WRITE) && waitreq_q
            && !(AVS_WRITE && (AVS_ADDRESS == hps_pkg::IDX_SLOT_CTRL) && cmd_blocked);
        wr_go = AVS_WRITE && !waitreq_q;
        case (AVS_ADDRESS)
            hps_pkg::IDX_SLOT_STATUS:
            begin
                rd_word = {16'h0, f_status(flags_q, sync_q)};
            end
            hps_pkg::IDX_SLOT_CTRL:
            begin
                rd_word = {19'h0, ctl_q};
            end
            hps_pkg::IDX_IRQ_MASK:
            begin
                rd_word = {23'h0, mask_q};
            end
            default:
            begin
                rd_word = 32'h0;
            end
        endcase
        waitreq_d = !accept;
        rdata_d = (accept && AVS_READ) ? rd_word : rdata_q;
    end

    always_ff @(posedge SYS_CLK or posedge RESET)
    begin
        if (RESET)
        begin
            waitreq_q <= 1'b1;
            rdata_q <= 32'h0;
        end
        else
        begin
            waitreq_q <= waitreq_d;
            rdata_q <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Slot control command and expander handshake

    always_comb
    begin
        ctl_d = ctl_q;
        busy_d = busy_q;
        req_d = req_q;
        cmd_done = busy_q && sync_q[hps_pkg::PIN_DONE];
        if (cmd_done)
        begin
            busy_d = 1'b0;
            req_d = 1'b0;
        end
        if (wr_go && (AVS_ADDRESS == hps_pkg::IDX_SLOT_CTRL))
        begin
            // The whole write, any fields, starts a single command
            ctl_d = (ctl_q & ~wr_mask[12:0]) | (AVS_WRITEDATA[12:0] & wr_mask[12:0]);
            busy_d = 1'b1;
            req_d = 1'b1;
        end
    end

    always_ff @(posedge SYS_CLK or posedge RESET)
    begin
        if (RESET)
        begin
            ctl_q <= hps_pkg::CTL_RST;
            busy_q <= 1'b0;
            req_q <= 1'b0;
        end
        else
        begin
            ctl_q <= ctl_d;
            busy_q <= busy_d;
            req_q <= req_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sticky event flags and mask

    always_comb
    begin
        evt_set = 9'h0;
        evt_set[hps_pkg::BIT_BUTTON] = sync_q[hps_pkg::PIN_BUTTON] && !prev_q[hps_pkg::PIN_BUTTON];
        evt_set[hps_pkg::BIT_PFAULT] = sync_q[hps_pkg::PIN_PFAULT] && !prev_q[hps_pkg::PIN_PFAULT];
        evt_set[hps_pkg::BIT_LATCH_CHG] = sync_q[hps_pkg::PIN_LATCH] ^ prev_q[hps_pkg::PIN_LATCH];
        evt_set[hps_pkg::BIT_PRES_CHG] = sync_q[hps_pkg::PIN_PRES] ^ prev_q[hps_pkg::PIN_PRES];
        evt_set[hps_pkg::BIT_CMD_DONE] = cmd_done;
        evt_set[hps_pkg::BIT_LINK_CHG] = LINK_ACTIVE ^ link_prev_q;
        evt_clr = 9'h0;
        mask_d = mask_q;
        if (wr_go && (AVS_ADDRESS == hps_pkg::IDX_SLOT_STATUS))
        begin
            // Writing one clears, zero leaves the bit alone
            evt_clr = AVS_WRITEDATA[8:0] & wr_mask[8:0] & hps_pkg::EVT_BITS;
        end
        if (wr_go && (AVS_ADDRESS == hps_pkg::IDX_IRQ_MASK))
        begin
            mask_d = ((mask_q & ~wr_mask[8:0]) | (AVS_WRITEDATA[8:0] & wr_mask[8:0])) & hps_pkg::EVT_BITS;
        end
        // A new event in the clearing cycle survives
        flags_d = (flags_q & ~evt_clr) | evt_set;
    end

    always_ff @(posedge SYS_CLK or posedge RESET)
    begin
        if (RESET)
        begin
            flags_q <= hps_pkg::FLAGS_RST;
            mask_q <= hps_pkg::MASK_RST;
        end
        else
        begin
            flags_q <= flags_d;
            mask_q <= mask_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt

    always_comb
    begin
        irq_gate = mask_q;
        irq_gate[hps_pkg::BIT_PRES_CHG] = mask_q[hps_pkg::BIT_PRES_CHG]
            && ctl_q[hps_pkg::CTL_PRES_IRQ_EN];
        irq_d = |(flags_q & irq_gate);
    end

    always_ff @(posedge SYS_CLK or posedge RESET)
    begin
        if (RESET)
        begin
            irq_q <= 1'b0;
        end
        else
        begin
            irq_q <= irq_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign AVS_READDATA = rdata_q;
    assign AVS_WAITREQUEST = waitreq_q;
    assign EXP_REQ = req_q;
    assign SLOT_CTRL = {3'h0, ctl_q};
    assign HP_IRQ = irq_q;

endmodule // hps_top

`default_nettype wire

// ===== verilog/hps_pkg.sv
// Purpose: Constants for the hot-plug slot status register bank
// Assumes: Register indices are word addresses; byte address is four times the index
// Notes: Shared by the design and the bench
`default_nettype none
package hps_pkg;
    // Register indices (word addresses on the bus)
    localparam logic [7:0] IDX_SLOT_CTRL = 8'h58;
    localparam logic [7:0] IDX_SLOT_STATUS = 8'h5a;
    localparam logic [7:0] IDX_DEV_CAP2 = 8'h64;
    localparam logic [7:0] IDX_DEV_CTL2 = 8'h68;
    localparam logic [7:0] IDX_DEV_STS2 = 8'h6a;
    localparam logic [7:0] IDX_LINK_CAP2 = 8'h6c;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h80;
    // Slot status bit positions
    localparam int BIT_BUTTON = 0;
    localparam int BIT_PFAULT = 1;
    localparam int BIT_LATCH_CHG = 2;
    localparam int BIT_PRES_CHG = 3;
    localparam int BIT_CMD_DONE = 4;
    localparam int BIT_LATCH_ST = 5;
    localparam int BIT_PRES_ST = 6;
    localparam int BIT_LOCK_ST = 7;
    localparam int BIT_LINK_CHG = 8;
    localparam int STATUS_W = 9;
    // Sticky event bits of slot status and of the mask
    localparam logic [8:0] EVT_BITS = 9'h11f;
    // Slot control: presence change interrupt enable, writable field width
    localparam int CTL_PRES_IRQ_EN = 3;
    localparam int CTL_W = 13;
    localparam logic [12:0] CTL_RST = 13'h0;
    // Synchronised pins: button, fault, latch, presence, interlock, expander done
    localparam int PIN_W = 6;
    localparam int PIN_BUTTON = 0;
    localparam int PIN_PFAULT = 1;
    localparam int PIN_LATCH = 2;
    localparam int PIN_PRES = 3;
    localparam int PIN_LOCK = 4;
    localparam int PIN_DONE = 5;
    // Presence reads one out of reset
    localparam logic [5:0] PIN_RST = 6'h08;
    localparam logic [8:0] FLAGS_RST = 9'h000;
    localparam logic [8:0] MASK_RST = 9'h000;
endpackage
`default_nettype wire

// ===== tb/hps_assertions.sv
// Purpose: Port checks of the slot status bank
// Assumes: Sees only the top ports
// Notes: Bound to hps_top
`timescale 1ns/10ps
`default_nettype none
module hps_assertions
(
    input wire logic SYS_CLK,
    input wire logic RESET,
    input wire logic [7:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_READDATA,
    input wire logic AVS_WAITREQUEST,
    input wire logic LATCH_OPEN,
    input wire logic CARD_PRESENT,
    input wire logic INTERLOCK_ENGAGED,
    input wire logic EXP_DONE,
    input wire logic EXP_REQ,
    input wire logic [15:0] SLOT_CTRL,
    input wire logic HP_IRQ
);
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (RESET);
    wire [2:0] live = {INTERLOCK_ENGAGED, CARD_PRESENT, LATCH_OPEN};
    wire ack = !AVS_WAITREQUEST;
    wire st_rd = ack && AVS_READ && AVS_ADDRESS == hps_pkg::IDX_SLOT_STATUS;
    wire ctl_wr = ack && AVS_WRITE && AVS_ADDRESS == hps_pkg::IDX_SLOT_CTRL;
    property p_rsv_zero;
        ack && AVS_READ && AVS_ADDRESS inside {8'h64, 8'h68, 8'h6a, 8'h6c, 8'h10} |-> AVS_READDATA == 32'h0;
    endproperty
    a_rsv_zero: assert property (p_rsv_zero) else $error("reserved read not zero");
    property p_st_top;
        st_rd |-> AVS_READDATA[31:9] == 23'h0;
    endproperty
    a_st_top: assert property (p_st_top) else $error("status top bits not zero");
    property p_live;
        st_rd && live == $past(live) && live == $past(live, 2) && live == $past(live, 3) |-> AVS_READDATA[7:5] == live;
    endproperty
    a_live: assert property (p_live) else $error("live bits wrong");
    property p_irq_fall;
        $fell(HP_IRQ) |-> $past(AVS_WRITE) || $past(AVS_WRITE, 2);
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq fell without write");
    property p_req_rise;
        $rose(EXP_REQ) |-> $past(ctl_wr);
    endproperty
    a_req_rise: assert property (p_req_rise) else $error("command without write");
    property p_req_start;
        ctl_wr |=> EXP_REQ;
    endproperty
    a_req_start: assert property (p_req_start) else $error("write did not start command");
    property p_req_end;
        $fell(EXP_REQ) |-> $past(EXP_DONE, 2);
    endproperty
    a_req_end: assert property (p_req_end) else $error("command ended early");
    property p_ctl_hold;
        $changed(SLOT_CTRL) |-> $past(ctl_wr) && SLOT_CTRL[15:13] == 3'h0;
    endproperty
    a_ctl_hold: assert property (p_ctl_hold) else $error("slot control changed alone");
endmodule // hps_assertions
bind hps_top hps_assertions u_chk (.SYS_CLK(SYS_CLK), .RESET(RESET), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .LATCH_OPEN(LATCH_OPEN),
    .CARD_PRESENT(CARD_PRESENT), .INTERLOCK_ENGAGED(INTERLOCK_ENGAGED), .EXP_DONE(EXP_DONE), .EXP_REQ(EXP_REQ),
    .SLOT_CTRL(SLOT_CTRL), .HP_IRQ(HP_IRQ));
`default_nettype wire

// ===== tb/hps_exp_model.sv
// Purpose: Expander engine stand-in
// Assumes: Done follows request after dly plus one cycles
// Notes: Done drops once request falls
`timescale 1ns/10ps
`default_nettype none
module hps_exp_model
(
    input wire logic clk,
    input wire logic rst,
    input wire logic req,
    input wire logic [3:0] dly,
    output logic done
);
    logic [3:0] cnt_q;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cnt_q <= 4'h0;
            done <= 1'b0;
        end
        else if (!req)
        begin
            cnt_q <= 4'h0;
            done <= 1'b0;
        end
        else if (cnt_q == dly)
            done <= 1'b1;
        else
            cnt_q <= cnt_q + 4'h1;
    end
endmodule // hps_exp_model
`default_nettype wire

// ===== tb/hps_top_tb_top.sv
// Purpose: Random and corner tests of the slot status bank
// Assumes: Word addressed bus, expander stand-in
// Notes: Flags are modelled in the bench
`timescale 1ns/10ps
`default_nettype none
module hps_top_tb_top;
    logic SYS_CLK = 1'b0;
    logic RESET = 1'b1;
    logic [7:0] AVS_ADDRESS = 8'h0;
    logic AVS_READ = 1'b0;
    logic AVS_WRITE = 1'b0;
    logic [31:0] AVS_WRITEDATA = 32'h0;
    logic [31:0] AVS_READDATA;
    logic AVS_WAITREQUEST, EXP_DONE, EXP_REQ, HP_IRQ;
    logic [4:0] PINS = 5'h08;
    logic LINK_ACTIVE = 1'b0;
    logic [15:0] SLOT_CTRL;
    logic [3:0] dly = 4'h0;
    logic [31:0] q, r;
    logic [8:0] flags = 9'h0;
    logic [8:0] mask = 9'h0;
    logic ctl3 = 1'b0;
    logic [7:0] rsv [5] = '{8'h64, 8'h68, 8'h6a, 8'h6c, 8'h10};
    int errors = 0;
    int total_checks = 0;
    initial
        forever #5 SYS_CLK = ~SYS_CLK;
    hps_top dut (.SYS_CLK(SYS_CLK), .RESET(RESET), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
        .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(4'hf), .AVS_READDATA(AVS_READDATA),
        .AVS_WAITREQUEST(AVS_WAITREQUEST), .ATTN_BUTTON(PINS[0]), .POWER_FAULT(PINS[1]), .LATCH_OPEN(PINS[2]),
        .CARD_PRESENT(PINS[3]), .INTERLOCK_ENGAGED(PINS[4]), .LINK_ACTIVE(LINK_ACTIVE), .EXP_DONE(EXP_DONE),
        .EXP_REQ(EXP_REQ), .SLOT_CTRL(SLOT_CTRL), .HP_IRQ(HP_IRQ));
    hps_exp_model u_exp (.clk(SYS_CLK), .rst(RESET), .req(EXP_REQ), .dly(dly), .done(EXP_DONE));
    task automatic give_verdict();
        if (errors == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e)
        begin
            errors++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge SYS_CLK);
    endtask
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge SYS_CLK);
        AVS_ADDRESS <= a;
        AVS_WRITE <= w;
        AVS_READ <= !w;
        AVS_WRITEDATA <= d;
        do
        begin
            @(posedge SYS_CLK);
            n++;
        end
        while (AVS_WAITREQUEST !== 1'b0 && n < 300);
        if (AVS_WAITREQUEST !== 1'b0)
        begin
            errors++;
            give_verdict();
        end
        q = AVS_READDATA;
        AVS_READ <= 1'b0;
        AVS_WRITE <= 1'b0;
    endtask
    task automatic cmd(input logic [12:0] c);
        int n;
        n = 0;
        acc(1'b1, hps_pkg::IDX_SLOT_CTRL, {19'h0, c});
        if (dly > 4'h3)
        begin
            acc(1'b0, hps_pkg::IDX_SLOT_STATUS, 32'h0);
            chk("done_early", {31'h0, q[4]}, {31'h0, flags[4]});
        end
        // The request rises at the answer edge, so look from the next edge on
        do
        begin
            tick(1);
            n++;
        end
        while (EXP_REQ !== 1'b0 && n < 100);
        if (EXP_REQ !== 1'b0)
        begin
            errors++;
            give_verdict();
        end
        chk("slot_ctrl", {16'h0, SLOT_CTRL}, {19'h0, c});
        acc(1'b0, hps_pkg::IDX_SLOT_CTRL, 32'h0);
        chk("ctl_read", q, {19'h0, c});
        ctl3 = c[3];
        flags[4] = 1'b1;
    endtask
    initial
    begin
        void'($urandom(32'h4a0ed97d));
        repeat (4) @(posedge SYS_CLK);
        RESET <= 1'b0;
        acc(1'b0, hps_pkg::IDX_SLOT_STATUS, 32'h0);
        chk("status_rst", q, 32'h40);
        foreach (rsv[i])
        begin
            acc(1'b1, rsv[i], 32'hffffffff);
            acc(1'b0, rsv[i], 32'h0);
            chk("reserved", q, 32'h0);
        end
        for (int i = 0; i < 40; i++)
        begin
            r = $urandom;
            dly <= r[3:0];
            acc(1'b1, hps_pkg::IDX_IRQ_MASK, r);
            mask = r[8:0] & hps_pkg::EVT_BITS;
            acc(1'b0, hps_pkg::IDX_IRQ_MASK, 32'h0);
            chk("mask_read", q, {23'h0, mask});
            if (r[9])
                cmd(r[22:10]);
            r = (i == 1) ? 32'h3f : $urandom;
            PINS <= {r[4], PINS[3:2] ^ r[3:2], r[1:0]};
            LINK_ACTIVE <= LINK_ACTIVE ^ r[5];
            flags = flags | {r[5], 4'h0, r[3:0]};
            tick(4);
            PINS[1:0] <= 2'b00;
            tick(4);
            acc(1'b0, hps_pkg::IDX_SLOT_STATUS, 32'h0);
            chk("status", q, {23'h0, flags[8], PINS[4:2], flags[4:0]});
            chk("irq", {31'h0, HP_IRQ}, {31'h0, |(flags & mask & {5'h1f, ctl3, 3'h7})});
            r = (i == 0) ? 32'hffffffff : $urandom;
            acc(1'b1, hps_pkg::IDX_SLOT_STATUS, r);
            flags = flags & ~(r[8:0] & hps_pkg::EVT_BITS);
            tick(2);
            chk("irq_clr", {31'h0, HP_IRQ}, {31'h0, |(flags & mask & {5'h1f, ctl3, 3'h7})});
        end
        give_verdict();
    end
endmodule // hps_top_tb_top
`default_nettype wire
